// ==== hdl/asp_consts.svh ====
// Constants of the converter sequencer and power control block
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// ==========================================================================
// Serial frame
`define ASP_WORD_BITS      5'h10
`define ASP_LIST_EDGE      5'h0b
`define ASP_CTRL_EDGE      5'h0f
`define ASP_SCLK_EDGE_PD   5'h0f

// ==========================================================================
// Register select codes (two bits after the write bit)
`define ASP_SEL_CTRL       2'h0
`define ASP_SEL_RANGE1     2'h1
`define ASP_SEL_RANGE2     2'h2
`define ASP_SEL_LIST       2'h3

// ==========================================================================
// Field codes
`define ASP_PM_NORMAL      2'h0
`define ASP_PM_FULL_DOWN   2'h3
`define ASP_MODE_PSEUDO    2'h3
`define ASP_TEMP_CHAN      3'h7

// ==========================================================================
// Reset values
`define ASP_CTRL_RST       12'h000
`define ASP_LIST_RST       8'h00
`define ASP_RANGE_RST      8'h00
`define ASP_SYNC_INIT      4'h1

`endif

// ==== hdl/asp_next_chan.sv ====
// Picks the next listed channel at or above a start index, with wrap
`timescale 1ns/1ps
module asp_next_chan (
  // Channel list and search start
  input  wire logic [7:0] list_i,
  input  wire logic [2:0] from_i,
  // Result
  output logic      [2:0] chan_o,
  output logic            any_o
);

  logic [2:0] above;            // Lowest listed index at or above start
  logic       above_hit;
  logic [2:0] lowest;           // Lowest listed index overall

  // ========================================================================
  // Descending scan leaves the smallest matching index
  always_comb begin
    above     = 3'h0;
    above_hit = 1'b0;
    lowest    = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (list_i[i]) begin
        lowest = 3'(i);
        if (3'(i) >= from_i) begin
          above     = 3'(i);
          above_hit = 1'b1;
        end
      end
    end
    chan_o = above_hit ? above : lowest;  // Wrap to the lowest listed
    any_o  = |list_i;
  end

endmodule // asp_next_chan

// ==== hdl/asp_pkg.sv ====
// Types of the converter sequencer and power control block
package asp_pkg;

  // ========================================================================
  // Control word layout, most significant field first
  typedef struct packed {
    logic [2:0] chan_addr;      // channel_addr_bit2..0
    logic [1:0] input_mode;     // Pseudo-differential when both set
    logic       power_mode_hi;
    logic       power_mode_lo;
    logic       coding;         // Output coding select
    logic       ref_int;        // Internal reference when set
    logic       sequencer_select_hi;
    logic       sequencer_select_lo;
    logic       spare;          // Always written zero
  } asp_ctrl_type;

  // ========================================================================
  // Register write carried from the link to the system side
  typedef struct packed {
    logic [1:0]  sel;           // Register select
    logic [11:0] data;          // Control word, or list/range in low byte
  } asp_wr_type;

  // ========================================================================
  // Sequencer modes and link power states
  typedef enum logic [1:0] {
    ASP_SEQ_SINGLE = 2'b00,
    ASP_SEQ_LIST   = 2'b01,
    ASP_SEQ_CONSEC = 2'b10,
    ASP_SEQ_SINGLE2 = 2'b11
  } asp_seq_type;

  typedef enum logic {
    ASP_PWR_ON   = 1'b0,
    ASP_PWR_DOWN = 1'b1
  } asp_pwr_type;

endpackage

// ==== hdl/asp_seq_power.sv ====
// Serial link, register file, channel sequencer and power control
// Behaviour
// - Power-up loads defaults into all four registers
// - List mode repeats listed channels while unchanged
// - Restarted list sequence begins at first channel
// - Consecutive mode runs channel zero to address
// - Consecutive mode continues without further writes
// - Select codes 00/11 convert the addressed channel
// - Reference bit one selects internal, resets zero
// - Result during reference-enable write is invalid
// - Power code 00 is normal, the default
// - Chip select fall starts conversion, enters hold
// - Written word loads the selected register
// - Power code 11 shuts down, keeps registers
// - Shutdown entered on fifteenth rising clock edge
// - Power-up from shutdown on fifteenth rising edge
// - Control latched edge 15, others edge 11
// - Output word: channel id, sign, twelve bits
// - Channel list holds one bit per channel
// - Range registers hold two bits per channel
`timescale 1ns/1ps
`include "asp_consts.svh"
module asp_seq_power (
  // System clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rstn_i,
  // Serial link pins from the host
  input  wire logic                  sclk_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  din_i,
  output logic                       dout_o,
  output logic                       dout_oe_o,
  // Converter core result, same clock domain
  input  wire logic [12:0]           adc_data_i,
  input  wire logic                  adc_valid_i,
  // Controls towards the analog front end
  output logic                       conv_start_o,
  output logic                       hold_o,
  output logic [2:0]                 conv_chan_o,
  output logic [1:0]                 conv_range_o,
  output logic [1:0]                 input_mode_o,
  output logic                       coding_o,
  output logic                       ref_int_o,
  output logic                       temp_sel_o,
  output logic                       power_down_o,
  // Register contents for observation
  output asp_pkg::asp_ctrl_type      ctrl_o,
  output logic [7:0]                 chan_list_o,
  output logic [15:0]                range_o
);
  import asp_pkg::*;

  // ========================================================================
  // Link domain state (sclk_i)
  logic        frame_rst_n;     // Low outside a frame or under reset
  logic [4:0]  bit_cnt_reg;     // Falling edges seen in this frame
  logic [14:0] din_sh_reg;      // Data-in shift register
  logic        ctrl_hit_reg;    // Control word taken in this frame
  asp_wr_type  wr_msg_reg;      // Last write, held stable for the crossing
  logic        wr_tog_reg;      // Toggles once per register write
  logic        done_tog_reg;    // Toggles at the sixteenth falling edge
  asp_pwr_type pwr_state_reg;   // Link view of the power state
  asp_ctrl_type new_ctrl;       // Control word as it arrives
  logic [15:0] tx_word_reg;     // Output word, system side, frame-stable

  // ========================================================================
  // System domain state
  logic [3:0]   sync_out;       // cs, write toggle, done toggle, power
  logic         cs_n_s;
  logic         cs_n_d_reg;
  logic         wr_tog_d_reg;
  logic         done_tog_d_reg;
  logic         wr_evt;
  logic         conv_evt;
  logic         done_evt;
  logic         frame_act_reg;  // Between conversion start and its end
  asp_ctrl_type ctrl_reg;
  logic [7:0]   list_reg;
  logic [7:0]   range1_reg;
  logic [7:0]   range2_reg;
  logic         restart_reg;    // Next list/consecutive conversion restarts
  logic [2:0]   cur_chan_reg;
  logic [2:0]   next_chan;
  logic         list_any;
  logic [2:0]   list_from;
  logic [2:0]   chan_next;
  asp_seq_type  seq_mode;

  // The frame counter is cleared by chip select itself, since the link
  // clock may stop while select is high.
  assign frame_rst_n = rstn_i & ~cs_n_i;
  assign new_ctrl    = asp_ctrl_type'({din_sh_reg[10:0], din_i});

  // ========================================================================
  // Frame counter and shift register, data taken on falling edges
  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_reg <= 5'h00;
      din_sh_reg  <= 15'h0000;
    end else begin
      if (bit_cnt_reg != `ASP_WORD_BITS) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
      din_sh_reg <= {din_sh_reg[13:0], din_i};
    end
  end

  // ========================================================================
  // Control hit flag, lives only until the sixteenth falling edge
  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      ctrl_hit_reg <= 1'b0;
    end else if (bit_cnt_reg == `ASP_CTRL_EDGE - 5'h01) begin
      // Write bit set and control selected on the fifteenth edge
      ctrl_hit_reg <= din_sh_reg[13] & (din_sh_reg[12:11] == `ASP_SEL_CTRL);
    end else begin
      ctrl_hit_reg <= 1'b0;
    end
  end

  // ========================================================================
  // Register writes latched on the link; persist across frames
  always_ff @(negedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_msg_reg   <= '0;
      wr_tog_reg   <= 1'b0;
      done_tog_reg <= 1'b0;
    end else if (!cs_n_i) begin
      if (bit_cnt_reg == `ASP_LIST_EDGE - 5'h01 && din_sh_reg[9] &&
          din_sh_reg[8:7] != `ASP_SEL_CTRL) begin
        // List or range word complete on the eleventh edge
        wr_msg_reg <= '{sel: din_sh_reg[8:7], data: {4'h0, din_sh_reg[6:0], din_i}};
        wr_tog_reg <= ~wr_tog_reg;
      end else if (bit_cnt_reg == `ASP_CTRL_EDGE - 5'h01 && din_sh_reg[13] &&
                   din_sh_reg[12:11] == `ASP_SEL_CTRL) begin
        // Control word complete on the fifteenth edge
        wr_msg_reg <= '{sel: `ASP_SEL_CTRL, data: new_ctrl};
        wr_tog_reg <= ~wr_tog_reg;
      end
      if (bit_cnt_reg == `ASP_WORD_BITS - 5'h01) begin
        done_tog_reg <= ~done_tog_reg;
      end
    end
  end

  // ========================================================================
  // Power state, changed on the fifteenth rising edge after a control write
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwr_state_reg <= ASP_PWR_ON;
    end else if (!cs_n_i && ctrl_hit_reg && bit_cnt_reg == `ASP_SCLK_EDGE_PD) begin
      case ({wr_msg_reg.data[6], wr_msg_reg.data[5]})
        `ASP_PM_FULL_DOWN: pwr_state_reg <= ASP_PWR_DOWN;
        `ASP_PM_NORMAL:    pwr_state_reg <= ASP_PWR_ON;
        default:           pwr_state_reg <= pwr_state_reg; // Auto modes not handled here
      endcase
    end
  end

  // ========================================================================
  // Data out: first bit shown at select fall, then one per falling edge.
  // The word is only changed by the system side outside a frame.
  assign dout_o    = tx_word_reg[4'hf - bit_cnt_reg[3:0]];
  assign dout_oe_o = ~cs_n_i & (bit_cnt_reg != `ASP_WORD_BITS);

  // ========================================================================
  // Crossing into the system clock
  asp_sync2 #(
    .WIDTH (4),
    .INIT  (`ASP_SYNC_INIT)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .async_i   ({pwr_state_reg == ASP_PWR_DOWN, done_tog_reg, wr_tog_reg, cs_n_i}),
    .sync_o    (sync_out)
  );

  assign cs_n_s   = sync_out[0];
  assign wr_evt   = sync_out[1] ^ wr_tog_d_reg;
  assign done_evt = sync_out[2] ^ done_tog_d_reg;
  assign conv_evt = cs_n_d_reg & ~cs_n_s;

  // ========================================================================
  // Edge detection delays
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_n_d_reg     <= 1'b1;
      wr_tog_d_reg   <= 1'b0;
      done_tog_d_reg <= 1'b0;
    end else begin
      cs_n_d_reg     <= cs_n_s;
      wr_tog_d_reg   <= sync_out[1];
      done_tog_d_reg <= sync_out[2];
    end
  end

  // ========================================================================
  // Register file; contents kept through shutdown
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg   <= `ASP_CTRL_RST;
      list_reg   <= `ASP_LIST_RST;
      range1_reg <= `ASP_RANGE_RST;
      range2_reg <= `ASP_RANGE_RST;
    end else if (wr_evt) begin
      case (wr_msg_reg.sel)
        `ASP_SEL_CTRL:   ctrl_reg   <= wr_msg_reg.data;
        `ASP_SEL_RANGE1: range1_reg <= wr_msg_reg.data[7:0];
        `ASP_SEL_RANGE2: range2_reg <= wr_msg_reg.data[7:0];
        `ASP_SEL_LIST:   list_reg   <= wr_msg_reg.data[7:0];
        default:         list_reg   <= list_reg;
      endcase
    end
  end

  // ========================================================================
  // Sequencer mode and next channel choice
  assign seq_mode  = asp_seq_type'({ctrl_reg.sequencer_select_hi,
                                    ctrl_reg.sequencer_select_lo});
  assign list_from = restart_reg ? 3'h0 : cur_chan_reg + 3'h1;

  asp_next_chan u_next (
    .list_i (list_reg),
    .from_i (list_from),
    .chan_o (next_chan),
    .any_o  (list_any)
  );

  always_comb begin
    case (seq_mode)
      // Listed channels in ascending order, repeating
      ASP_SEQ_LIST:   chan_next = list_any ? next_chan : cur_chan_reg;
      // Channel 0 up to the addressed channel, repeating
      ASP_SEQ_CONSEC: chan_next = (restart_reg || cur_chan_reg >= ctrl_reg.chan_addr) ?
                                  3'h0 : cur_chan_reg + 3'h1;
      // Both select codes 00 and 11 take the written address
      default:        chan_next = ctrl_reg.chan_addr;
    endcase
  end

  // ========================================================================
  // Current channel and restart flag; a control write beats a conversion
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_chan_reg <= 3'h0;
      restart_reg  <= 1'b1;
    end else begin
      if (conv_evt) begin
        cur_chan_reg <= chan_next;
      end
      if (wr_evt && wr_msg_reg.sel == `ASP_SEL_CTRL) begin
        restart_reg <= 1'b1;
      end else if (conv_evt) begin
        restart_reg <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Conversion frame tracking and output word capture
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_act_reg <= 1'b0;
      conv_start_o  <= 1'b0;
    end else begin
      conv_start_o <= conv_evt;
      if (conv_evt) begin
        frame_act_reg <= 1'b1;
      end else if (done_evt || cs_n_s) begin
        frame_act_reg <= 1'b0;
      end
    end
  end

  // Word only reloads between frames, so the link sees it quiet.
  // A result taken while the reference was just enabled is not marked;
  // the host drops it.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_word_reg <= 16'h0000;
    end else if (adc_valid_i && !frame_act_reg && cs_n_d_reg == cs_n_s) begin
      tx_word_reg <= {cur_chan_reg, adc_data_i};
    end
  end

  // ========================================================================
  // Controls to the analog front end
  always_comb begin
    case (cur_chan_reg[1:0])
      2'h0:    conv_range_o = cur_chan_reg[2] ? range2_reg[7:6] : range1_reg[7:6];
      2'h1:    conv_range_o = cur_chan_reg[2] ? range2_reg[5:4] : range1_reg[5:4];
      2'h2:    conv_range_o = cur_chan_reg[2] ? range2_reg[3:2] : range1_reg[3:2];
      default: conv_range_o = cur_chan_reg[2] ? range2_reg[1:0] : range1_reg[1:0];
    endcase
  end

  assign hold_o       = frame_act_reg;
  assign conv_chan_o  = cur_chan_reg;
  assign input_mode_o = ctrl_reg.input_mode;
  assign coding_o     = ctrl_reg.coding;
  assign ref_int_o    = ctrl_reg.ref_int;
  assign temp_sel_o   = (ctrl_reg.input_mode == `ASP_MODE_PSEUDO) &&
                        (ctrl_reg.chan_addr == `ASP_TEMP_CHAN);
  assign power_down_o = sync_out[3];
  assign ctrl_o       = ctrl_reg;
  assign chan_list_o  = list_reg;
  assign range_o      = {range1_reg, range2_reg};

endmodule // asp_seq_power

// ==== hdl/asp_sync2.sv ====
// Two flip-flop level synchroniser of parameterised width
`timescale 1ns/1ps
module asp_sync2 #(
  parameter int          WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  // Levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;   // First stage, read only by the second

  // ========================================================================
  // Two stages, both reset to the idle levels
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= INIT;
      sync_o   <= INIT;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule // asp_sync2

// ==== tb/asp_host_model.sv ====
// Host serial port model: drives select, serial clock and data in
`timescale 1ns/1ps
module asp_host_model (
  // Link pins towards the device
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i
);
  // ==========================================================================
  // Idle: clock stands high outside frames
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end

  // ==========================================================================
  // One frame of n clocks, 80 ns period; fewer than 16 aborts early
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = '0;
    #1.3; // Keep link edges off the system clock edges, phase is unrelated
    cs_n_o = 1'b0;
    din_o = w[15];
    #40;
    for (int i = 0; i < n; i++) begin
      r[15-i] = dout_i; // Bit settled since previous falling edge
      sclk_o = 1'b0;
      #40;
      sclk_o = 1'b1;
      din_o = (i < 15) ? w[14-i] : ~din_o;
      #40;
    end
    cs_n_o = 1'b1;
    din_o = ~din_o; // Not selected: no stale value left on the line
  endtask
endmodule // asp_host_model

// ==== tb/asp_seq_power_bench.sv ====
// Self-checking bench for the sequencer and power control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module asp_seq_power_bench;
  import asp_pkg::*;
  // ==========================================================================
  // Signals
  logic         clk_sys_i   = 1'b0;
  logic         rstn_i      = 1'b0;
  logic [12:0]  adc_data_i  = '0;
  logic         adc_valid_i = 1'b0;
  logic         sclk, cs_n, din, dout, coding_o, ref_int_o, temp_sel_o, power_down_o;
  asp_ctrl_type ctrl_o;
  logic [7:0]   chan_list_o;
  logic [15:0]  range_o, rx;
  logic [12:0]  d_last = '0;      // Last result handed to the device
  int           errors = 0, n_tests = 0, cyc = 0;
  logic [1:0]   sq[4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  logic [2:0]   ad[4] = '{3'h5, 3'h3, 3'h0, 3'h2};
  logic [14:0]  ex[4] = '{{5{3'h5}}, {5{3'h3}}, {3'h0, 3'h7, 3'h5, 3'h2, 3'h0},
                        {3'h1, 3'h0, 3'h2, 3'h1, 3'h0}};

  always #2.5 clk_sys_i = ~clk_sys_i;

  asp_seq_power dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .dout_o(dout), .dout_oe_o(), .adc_data_i(adc_data_i), .adc_valid_i(adc_valid_i),
    .conv_start_o(), .hold_o(), .conv_chan_o(), .conv_range_o(), .input_mode_o(),
    .coding_o(coding_o), .ref_int_o(ref_int_o), .temp_sel_o(temp_sel_o),
    .power_down_o(power_down_o), .ctrl_o(ctrl_o), .chan_list_o(chan_list_o),
    .range_o(range_o));

  asp_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));

  // ==========================================================================
  // Word builders and access tasks
  function automatic logic [15:0] cw(input logic [2:0] a, input logic [1:0] m,
                                     input logic [1:0] pm, input logic r,
                                     input logic [1:0] s);
    return {1'b1, 2'h0, a, m, pm, 1'b0, r, s, 2'h0};
  endfunction
  function automatic logic [15:0] rw(input logic [1:0] s, input logic [7:0] v);
    return {1'b1, s, v, 5'h00};
  endfunction

  // Frame, then a fresh converter result loaded between frames
  task automatic frame(input logic [15:0] w, input int n = 16);
    host.xfer(w, n, rx);
    repeat (8) @(posedge clk_sys_i);
    d_last = d_last + 13'h0a53;
    adc_data_i <= d_last;
    adc_valid_i <= 1'b1;
    @(posedge clk_sys_i) adc_valid_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
  endtask

  // Control write, then idle frames with data in low; id lags one frame
  task automatic seq_run(input logic [15:0] w, input logic [14:0] e);
    logic [12:0] dp;
    frame(w);
    frame(16'h0000);
    for (int i = 0; i < 5; i++) begin
      dp = d_last;
      frame(16'h0000);
      `CHK("chan id", e[3*i +: 3], rx[15:13])
      `CHK("result", dp, rx[12:0])
    end
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard: about three times the expected run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      $display("[ERR] run timeout exp done got hang");
      end_sim;
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    `CHK("ctrl", 12'h000, ctrl_o)
    `CHK("list", 8'h00, chan_list_o)
    `CHK("range", 16'h0000, range_o)
    `CHK("ref", 1'b0, ref_int_o)
    `CHK("coding", 1'b0, coding_o)
    `CHK("pd", 1'b0, power_down_o)
    $display("test reset done");
    frame(rw(2'h1, 8'h1b), 10);
    `CHK("range", 16'h0000, range_o)
    frame(rw(2'h1, 8'h1b));
    frame(rw(2'h2, 8'he4));
    `CHK("range", 16'h1be4, range_o)
    frame(rw(2'h3, 8'ha5), 11);
    `CHK("list", 8'ha5, chan_list_o)
    frame({1'b0, 2'h3, 8'hff, 5'h00});
    `CHK("list", 8'ha5, chan_list_o)
    frame(cw(3'h7, 2'h3, 2'h0, 1'b1, 2'h0), 14);
    `CHK("ctrl", 12'h000, ctrl_o)
    frame(cw(3'h7, 2'h3, 2'h0, 1'b1, 2'h0));
    `CHK("ctrl", 12'hf88, ctrl_o)
    `CHK("ref", 1'b1, ref_int_o)
    `CHK("temp", 1'b1, temp_sel_o)
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      seq_run(cw(ad[m], 2'h0, 2'h0, 1'b0, sq[m]), ex[m]);
    end
    frame(cw(3'h0, 2'h0, 2'h0, 1'b0, 2'h0));
    frame(rw(2'h1, 8'h40));
    `CHK("range", 16'h40e4, range_o)
    seq_run(cw(3'h0, 2'h0, 2'h0, 1'b0, 2'h1), ex[2]);
    $display("test sequencer done");
    frame(cw(3'h0, 2'h0, 2'h3, 1'b0, 2'h0));
    `CHK("pd", 1'b1, power_down_o)
    frame(16'h0000);
    `CHK("pd", 1'b1, power_down_o)
    `CHK("list", 8'ha5, chan_list_o)
    frame(cw(3'h0, 2'h0, 2'h0, 1'b0, 2'h0));
    `CHK("pd", 1'b0, power_down_o)
    $display("test power done");
    end_sim;
  end
endmodule // asp_seq_power_bench

// ==== tb/asp_seq_power_sva.sv ====
// Port-level checker for the sequencer and power control block
`timescale 1ns/1ps
module asp_seq_power_sva
  import asp_pkg::*;
(
  // Clock and reset
  input wire logic         clk_sys_i,
  input wire logic         rstn_i,
  // Link and converter controls
  input wire logic         cs_n_i,
  input wire logic         dout_oe_o,
  input wire logic         conv_start_o,
  input wire logic         hold_o,
  input wire logic [2:0]   conv_chan_o,
  input wire logic [1:0]   conv_range_o,
  input wire logic [1:0]   input_mode_o,
  input wire logic         ref_int_o,
  input wire logic         temp_sel_o,
  input wire logic         power_down_o,
  // Register contents
  input wire asp_ctrl_type ctrl_o,
  input wire logic [7:0]   chan_list_o,
  input wire logic [15:0]  range_o
);
  // ==========================================================================
  // Checks, all in the system clock domain
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_temp_sel_map: assert property (
    temp_sel_o == (ctrl_o.input_mode == 2'h3 && ctrl_o.chan_addr == 3'h7))
    else $error("temperature select disagrees with mode and address");
  a_ctrl_fields: assert property (
    ref_int_o == ctrl_o.ref_int && input_mode_o == ctrl_o.input_mode)
    else $error("reference or mode output disagrees with control word");
  a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("conversion start longer than one cycle");
  a_start_on_cs: assert property (
    $fell(cs_n_i) && !power_down_o |-> ##[2:6] conv_start_o)
    else $error("no conversion start after select fell");
  a_hold_follows: assert property (conv_start_o |-> ##[0:1] hold_o)
    else $error("hold not entered at conversion start");
  a_idle_no_oe: assert property (cs_n_i |-> !dout_oe_o)
    else $error("data out driven while deselected");
  a_range_map: assert property (
    conv_range_o == range_o[5'd15 - {1'b0, conv_chan_o, 1'b0} -: 2])
    else $error("range code does not belong to converted channel");
  a_regs_quiet: assert property (
    cs_n_i && $past(cs_n_i, 8) |->
      $stable(ctrl_o) && $stable(range_o) && $stable(chan_list_o))
    else $error("register changed with no frame");
  a_pd_enter: assert property (
    $rose(power_down_o) |-> ctrl_o.power_mode_hi && ctrl_o.power_mode_lo)
    else $error("shutdown without full shutdown code");
  a_pd_exit: assert property (
    $fell(power_down_o) |-> !ctrl_o.power_mode_hi && !ctrl_o.power_mode_lo)
    else $error("power up without normal code");
endmodule // asp_seq_power_sva

bind asp_seq_power asp_seq_power_sva u_sva (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .dout_oe_o(dout_oe_o),
  .conv_start_o(conv_start_o), .hold_o(hold_o), .conv_chan_o(conv_chan_o),
  .conv_range_o(conv_range_o), .input_mode_o(input_mode_o), .ref_int_o(ref_int_o),
  .temp_sel_o(temp_sel_o), .power_down_o(power_down_o), .ctrl_o(ctrl_o),
  .chan_list_o(chan_list_o), .range_o(range_o));
